/* inc/gac_defs.svh */
// Purpose: constants for the gated 16-bit counter
// Assumes: single clk_sys domain, byte-wide software access over plain ports
// Notes: gate source codes and prescale encodings kept here as macros
//
// Operation
// - unlatched external clock counts without alignment to internal phase ticks
// - asynchronous external counting continues in sleep; rollover can wake the core
// - switching sync/async may lose or add one increment
// - byte reads during asynchronous counting always return clean values
// - wide access enable routes high byte reads and writes to shadow
// - wide mode low read copies live high byte into shadow
// - wide mode low write loads both bytes, high from shadow
// - high byte write keeps prescaler; low byte write clears it
// - gate enabled: count only while gate matches polarity, else hold
// - five bit gate select; codes above last and own code read zero
// - comparator gate sources either sampled on count ticks or passed through
// - toggle mode routes gate through flip-flop toggling on rising edges of the polarity-adjusted gate
// - toggle mode cleared forces toggle flip-flop to zero
// - armed: enable at next gate edge, disarm at trailing edge
// - clearing one-shot mode clears the arm bit
// - toggle and one-shot together measure one complete gate cycle
// - gate level status valid even with gate enable cleared
// - gate level falling edge sets gate event flag regardless of enable
// - run enable required; gate enable adds gate control
// - prescaler divides selected clock by 1, 2, 4 or 8
// - counter wraps ffff to 0000 and sets rollover flag
`ifndef GAC_DEFS_SVH
`define GAC_DEFS_SVH

`define GAC_COUNT_RESET   16'h0000
`define GAC_COUNT_MAX     16'hffff
`define GAC_BYTE_RESET    8'h00
`define GAC_PRE_RESET     3'h0
`define GAC_PHASE_LAST    2'h3
`define GAC_INPUT_PRESCALE_DIV1     2'h0
`define GAC_INPUT_PRESCALE_DIV2     2'h1
`define GAC_INPUT_PRESCALE_DIV4     2'h2
`define GAC_INPUT_PRESCALE_DIV8     2'h3
`define GAC_GSS_PIN       5'h00
`define GAC_GSS_OWN       5'h02
`define GAC_GSS_CMP_FIRST 5'h13
`define GAC_GSS_CMP_LAST  5'h15
`define GAC_GSS_LAST      5'h16
`define GAC_GATE_SOURCES  23

`endif

/* inc/gac_pkg.sv */
// Purpose: shared types of the gated counter
// Assumes: nothing beyond SystemVerilog packages
// Notes: single-pulse sequencer states
package gac_pkg;
    typedef enum logic [1:0]
    {
        GAC_SP_IDLE  = 2'b00,
        GAC_SP_ARMED = 2'b01,
        GAC_SP_COUNT = 2'b10
    } gac_sp_state_t;
endpackage

/* inc/gac_pre_if.sv */
// Purpose: link between the counter core and its prescaler
// Assumes: both ends on clk_sys
// Notes: tick is combinational from the prescaler
interface gac_pre_if;
    logic       rawEdge;
    logic       clear;
    logic [1:0] input_prescale;
    logic       tick;
    modport core (output rawEdge, output clear, output input_prescale, input tick);
    modport pre  (input rawEdge, input clear, input input_prescale, output tick);
endinterface

/* rtl/gac_prescale.sv */
// Purpose: 1/2/4/8 prescaler ahead of the 16-bit counter
// Assumes: rawEdge is a one-cycle pulse per selected clock edge
// Notes: count is not visible to software, only cleared by it
`include "gac_defs.svh"
module gac_prescale (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic reset,
    // core link
    gac_pre_if.pre    link
);
    logic [2:0] preCount;
    logic [2:0] mask;

    // terminal count mask per prescale setting
    always_comb
    begin
        if (link.input_prescale == `GAC_INPUT_PRESCALE_DIV8)
            mask = 3'h7;
        else if (link.input_prescale == `GAC_INPUT_PRESCALE_DIV4)
            mask = 3'h3;
        else if (link.input_prescale == `GAC_INPUT_PRESCALE_DIV2)
            mask = 3'h1;
        else
            mask = 3'h0;
    end

    assign link.tick = link.rawEdge && ((preCount & mask) == mask);

    // clear beats an edge so a low write restarts the division cleanly
    always_ff @(posedge clk_sys)
    begin
        if (reset || link.clear)
            preCount <= `GAC_PRE_RESET;
        else if (link.rawEdge)
            preCount <= preCount + 3'h1;
    end

    a_pre_clear_only: assert property (@(posedge clk_sys) disable iff (reset)
        !link.clear && !link.rawEdge |=> $stable(preCount))
        else $error("prescaler moved without edge or clear");
    a_pre_div8: assert property (@(posedge clk_sys) disable iff (reset)
        link.tick && link.input_prescale == `GAC_INPUT_PRESCALE_DIV8 && !link.clear |-> preCount == 3'h7)
        else $error("divide by eight tick off count");
endmodule // gac_prescale

/* rtl/gac_sync2.sv */
// Purpose: two-stage synchroniser for pin and foreign-domain levels
// Assumes: inputs are slow levels compared to clk_sys
// Notes: first stage is read only by the second
module gac_sync2 #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             reset,
    // levels
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1;

    // plain double flop, no logic between stages
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            stage1  <= '0;
            syncOut <= '0;
        end
        else
        begin
            stage1  <= asyncIn;
            syncOut <= stage1;
        end
    end
endmodule // gac_sync2

/* rtl/gac_top.sv */
// Purpose: 16-bit gated counter with byte access, shadow high byte and gate logic
// Assumes: software strobes are one-cycle pulses on clk_sys; gate sources and
//          external clock are foreign levels
// Notes: one clock only; the "asynchronous" mode skips phase alignment
`include "gac_defs.svh"
module gac_top (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset,
    // clocking controls
    input  wire logic        extClkPin,
    input  wire logic        clkSourceExt,
    input  wire logic        extClkUnlatched,
    input  wire logic        sleepMode,
    input  wire logic [1:0]  inputPrescale,
    // counter controls
    input  wire logic        runEnable,
    input  wire logic        wideAccessEnable,
    // byte access
    input  wire logic        wrLowStrobe,
    input  wire logic        wrHighStrobe,
    input  wire logic        rdLowStrobe,
    input  wire logic        rdHighStrobe,
    input  wire logic [7:0]  wrData,
    output logic      [7:0]  rdData,
    output logic      [15:0] countValue,
    // gate controls
    input  wire logic        gateEnable,
    input  wire logic        gatePolarity,
    input  wire logic [4:0]  gateSourceSelect,
    input  wire logic [22:0] gateSources,
    input  wire logic        compSyncEnable,
    input  wire logic        toggleGateMode,
    input  wire logic        oneShotGateMode,
    input  wire logic        armSetStrobe,
    output logic             singlePulseArm,
    output logic             gateLevel,
    // event flags
    output logic             rolloverFlag,
    input  wire logic        rolloverClear,
    input  wire logic        rolloverEnable,
    output logic             wakeRequest,
    output logic             gateEventFlag,
    input  wire logic        gateFlagClear,
    input  wire logic        gateEventEnable,
    output logic             gateEventIrq
);
    // synchronised inputs
    logic                   extClkSync;
    logic [22:0]            srcSync;
    // phase and edge detection
    logic [1:0]             phaseCount;
    logic                   phaseTick;
    logic                   extLatched;
    logic                   extLevel;
    logic                   extPrev;
    logic                   rawEdge;
    // counter state
    logic [15:0]            count;
    logic [7:0]             shadowHigh;
    logic                   cntTick;
    logic                   countWrite;
    logic                   countEnable;
    // gate path
    logic [22:0]            cmpHeld;
    logic                   selGate;
    logic                   polGate;
    logic                   polPrev;
    logic                   toggleFf;
    logic                   gateNow;
    logic                   gateRise;
    logic                   gateFall;
    logic                   spCountOk;
    logic                   gateOk;
    gac_pkg::gac_sp_state_t spState;

    gac_pre_if preLink ();

    // pin clock and gate sources cross into clk_sys here
    gac_sync2 #(.WIDTH(1)) u_clk_sync (
        .clk_sys (clk_sys),
        .reset   (reset),
        .asyncIn (extClkPin),
        .syncOut (extClkSync)
    );

    gac_sync2 #(.WIDTH(`GAC_GATE_SOURCES)) u_gate_sync (
        .clk_sys (clk_sys),
        .reset   (reset),
        .asyncIn (gateSources),
        .syncOut (srcSync)
    );

    gac_prescale u_prescale (
        .clk_sys (clk_sys),
        .reset   (reset),
        .link    (preLink)
    );

    // internal phase divider, stands still in sleep like the core clock
    always_ff @(posedge clk_sys)
    begin
        if (reset || sleepMode)
            phaseCount <= 2'h0;
        else
            phaseCount <= phaseCount + 2'h1;
    end

    assign phaseTick = !sleepMode && (phaseCount == `GAC_PHASE_LAST);

    // latched mode samples the pin only on phase ticks; it is frozen in sleep
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            extLatched <= 1'b0;
        else if (phaseTick)
            extLatched <= extClkSync;
    end

    // unlatched mode bypasses the phase latch entirely, so it runs in sleep
    assign extLevel = extClkUnlatched ? extClkSync : extLatched;

    // switching modes changes which level feeds this detector, so one
    // increment may be lost or gained at the switch
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            extPrev <= 1'b0;
        else
            extPrev <= extLevel;
    end

    // rising external edge or internal phase tick feeds the prescaler
    always_comb
    begin
        if (clkSourceExt)
            rawEdge = extLevel && !extPrev;
        else
            rawEdge = phaseTick;
    end

    assign preLink.rawEdge = rawEdge;
    assign preLink.clear   = wrLowStrobe;
    assign preLink.input_prescale    = inputPrescale;

    // comparator copies taken on count ticks for the synchronised choice
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            cmpHeld <= '0;
        else if (preLink.tick)
            cmpHeld <= srcSync;
    end

    // gate source multiplexer; reserved codes and own overflow read low
    always_comb
    begin
        if (gateSourceSelect > `GAC_GSS_LAST || gateSourceSelect == `GAC_GSS_OWN)
            selGate = 1'b0;
        else if (gateSourceSelect >= `GAC_GSS_CMP_FIRST && gateSourceSelect <= `GAC_GSS_CMP_LAST)
            selGate = compSyncEnable ? cmpHeld[gateSourceSelect] : srcSync[gateSourceSelect];
        else
            selGate = srcSync[gateSourceSelect];
    end

    // polarity turns the gate into active-high form
    assign polGate = gatePolarity ? selGate : !selGate;

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            polPrev <= 1'b0;
        else
            polPrev <= polGate;
    end

    // toggle flip-flop; held clear so the measured edge is known
    always_ff @(posedge clk_sys)
    begin
        if (reset || !toggleGateMode)
            toggleFf <= 1'b0;
        else if (polGate && !polPrev)
            toggleFf <= !toggleFf;
    end

    assign gateNow  = toggleGateMode ? toggleFf : polGate;
    assign gateRise = gateNow && !gateLevel;
    assign gateFall = !gateNow && gateLevel;

    // gate level status follows the gate even when gating is off
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            gateLevel <= 1'b0;
        else
            gateLevel <= gateNow;
    end

    // single-pulse sequencer; leaving one-shot mode drops everything
    always_ff @(posedge clk_sys)
    begin
        if (reset || !oneShotGateMode)
            spState <= gac_pkg::GAC_SP_IDLE;
        else
        begin
            case (spState)
                gac_pkg::GAC_SP_IDLE:
                    if (singlePulseArm)
                        spState <= gac_pkg::GAC_SP_ARMED;
                gac_pkg::GAC_SP_ARMED:
                    if (gateRise)
                        spState <= gac_pkg::GAC_SP_COUNT;
                gac_pkg::GAC_SP_COUNT:
                    if (gateFall)
                        spState <= gac_pkg::GAC_SP_IDLE;
                default:
                    spState <= gac_pkg::GAC_SP_IDLE;
            endcase
        end
    end

    // arm bit: software sets, trailing edge clears; a set in the same cycle wins
    always_ff @(posedge clk_sys)
    begin
        if (reset || !oneShotGateMode)
            singlePulseArm <= 1'b0;
        else if (armSetStrobe)
            singlePulseArm <= 1'b1;
        else if (spState == gac_pkg::GAC_SP_COUNT && gateFall)
            singlePulseArm <= 1'b0;
    end

    // one-shot lets only the pulse after arming through
    always_comb
    begin
        if (!oneShotGateMode)
            spCountOk = 1'b1;
        else if (spState == gac_pkg::GAC_SP_COUNT)
            spCountOk = 1'b1;
        else if (spState == gac_pkg::GAC_SP_ARMED)
            spCountOk = gateRise;
        else
            spCountOk = 1'b0;
    end

    assign gateOk      = gateNow && spCountOk;
    assign countEnable = runEnable && (!gateEnable || gateOk);
    assign cntTick     = preLink.tick && countEnable;
    // writes win over a coinciding increment; software should stop first
    assign countWrite  = wrLowStrobe || (wrHighStrobe && !wideAccessEnable);

    // live counter
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            count <= `GAC_COUNT_RESET;
        else if (wrLowStrobe && wideAccessEnable)
            count <= {shadowHigh, wrData};
        else if (wrLowStrobe)
            count[7:0] <= wrData;
        else if (wrHighStrobe && !wideAccessEnable)
            count[15:8] <= wrData;
        else if (cntTick)
            count <= count + 16'h0001;
    end

    assign countValue = count;

    // shadow high byte: software preloads it, low reads snapshot into it
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            shadowHigh <= `GAC_BYTE_RESET;
        else if (wideAccessEnable && wrHighStrobe)
            shadowHigh <= wrData;
        else if (wideAccessEnable && rdLowStrobe)
            shadowHigh <= count[15:8];
    end

    // read data register; all state is on clk_sys so reads never tear
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            rdData <= `GAC_BYTE_RESET;
        else if (rdLowStrobe)
            rdData <= count[7:0];
        else if (rdHighStrobe)
            rdData <= wideAccessEnable ? shadowHigh : count[15:8];
    end

    // rollover flag; hardware set wins over software clear
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            rolloverFlag <= 1'b0;
        else if (cntTick && !countWrite && count == `GAC_COUNT_MAX)
            rolloverFlag <= 1'b1;
        else if (rolloverClear)
            rolloverFlag <= 1'b0;
    end

    // gate event flag; sticky until written to zero, not cleared by reads
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            gateEventFlag <= 1'b0;
        else if (gateFall)
            gateEventFlag <= 1'b1;
        else if (gateFlagClear)
            gateEventFlag <= 1'b0;
    end

    assign gateEventIrq = gateEventFlag && gateEventEnable;
    // only the unlatched external path keeps counting while asleep
    assign wakeRequest  = sleepMode && rolloverFlag && rolloverEnable;

    a_wrap_to_zero: assert property (@(posedge clk_sys) disable iff (reset)
        cntTick && !countWrite && count == `GAC_COUNT_MAX |=> count == `GAC_COUNT_RESET && rolloverFlag)
        else $error("counter did not wrap with rollover flag");

    a_low_read_snap: assert property (@(posedge clk_sys) disable iff (reset)
        wideAccessEnable && rdLowStrobe && !wrHighStrobe ##1 rdHighStrobe && !rdLowStrobe && wideAccessEnable
        |=> rdData == $past(count[15:8], 2))
        else $error("high read did not return snapshot");

    a_wide_low_write: assert property (@(posedge clk_sys) disable iff (reset)
        wideAccessEnable && wrLowStrobe |=> count == {$past(shadowHigh), $past(wrData)})
        else $error("wide low write did not load both bytes");

    a_wide_high_keep: assert property (@(posedge clk_sys) disable iff (reset)
        wideAccessEnable && wrHighStrobe && !wrLowStrobe && !cntTick |=> $stable(count))
        else $error("wide high write touched live counter");

    a_run_off_hold: assert property (@(posedge clk_sys) disable iff (reset)
        !runEnable && !wrLowStrobe && !wrHighStrobe |=> $stable(count))
        else $error("counter moved with run enable clear");

    a_gate_hold: assert property (@(posedge clk_sys) disable iff (reset)
        runEnable && gateEnable && !gateNow && !wrLowStrobe && !wrHighStrobe |=> $stable(count))
        else $error("counter moved with gate inactive");

    a_toggle_clear: assert property (@(posedge clk_sys) disable iff (reset)
        !toggleGateMode |=> !toggleFf)
        else $error("toggle flip-flop not held clear");

    a_oneshot_disarm: assert property (@(posedge clk_sys) disable iff (reset)
        !oneShotGateMode |=> !singlePulseArm && spState == gac_pkg::GAC_SP_IDLE)
        else $error("arm bit survived one-shot clear");

    a_pulse_done: assert property (@(posedge clk_sys) disable iff (reset)
        oneShotGateMode && spState == gac_pkg::GAC_SP_COUNT && gateFall && !armSetStrobe
        |=> !singlePulseArm ##1 spState == gac_pkg::GAC_SP_IDLE)
        else $error("arm bit not cleared at trailing edge");

    a_gate_fall_flag: assert property (@(posedge clk_sys) disable iff (reset)
        gateFall |=> gateEventFlag && !gateLevel)
        else $error("gate falling edge did not set flag");

    a_flag_sticky: assert property (@(posedge clk_sys) disable iff (reset)
        gateEventFlag && !gateFlagClear |=> gateEventFlag)
        else $error("gate event flag dropped without clear");

    a_reserved_low: assert property (@(posedge clk_sys) disable iff (reset)
        gateSourceSelect > `GAC_GSS_LAST |-> !selGate)
        else $error("reserved gate code not low");
endmodule // gac_top

/* test/gac_far_model.sv */
// Purpose: far side of the counter: external clock pin and gate source levels
// Assumes: clk_sys reference only; levels change just after a rising edge
// Notes: the external clock stands still low while clkRun is low
module gac_far_model (
    // clock
    input  wire logic        clk_sys,
    // commands from the bench
    input  wire logic        clkRun,
    input  wire logic [22:0] gateReq,
    // levels toward the counter
    output logic             extClkPin,
    output logic      [22:0] gateSources
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [1:0] phase = 2'h0;

    initial extClkPin = 1'b0;
    initial gateSources = 23'h000000;

    // external clock, one rising edge every eight system cycles
    always @(posedge clk_sys)
    begin
        phase <= phase + 2'h1;
        if (!clkRun)
            extClkPin <= 1'b0; // idle low, no stray edges
        else if (phase == 2'h3)
            extClkPin <= ~extClkPin;
    end

    // gate sources follow the bench request one edge later
    always @(posedge clk_sys)
    begin
        gateSources <= gateReq;
    end
endmodule // gac_far_model

/* test/gac_top_tb_top.sv */
// Purpose: self-checking bench for the gated 16-bit counter
// Assumes: inputs change on the falling edge, strobes last one cycle
// Notes: no random stimulus; waits are bounded
module gac_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk_sys = 0, reset = 1, clkSourceExt = 0, extClkUnlatched = 0, sleepMode = 0;
    logic        runEnable = 0, wideAccessEnable = 0, wrLowStrobe = 0, wrHighStrobe = 0;
    logic        rdLowStrobe = 0, rdHighStrobe = 0, gateEnable = 0, gatePolarity = 0;
    logic        compSyncEnable = 0, toggleGateMode = 0, oneShotGateMode = 0, armSetStrobe = 0;
    logic        rolloverClear = 0, rolloverEnable = 0, gateFlagClear = 0, gateEventEnable = 0;
    logic        clkRun = 0, extClkPin, singlePulseArm, gateLevel, rolloverFlag, wakeRequest;
    logic        gateEventFlag, gateEventIrq;
    logic [1:0]  inputPrescale = 2'h0;
    logic [4:0]  gateSourceSelect = 5'h00;
    logic [7:0]  wrData = 8'h00, rdData;
    logic [15:0] countValue, held;
    logic [22:0] gateReq = 23'h000000, gateSources;
    int          n_mismatch = 0, n_compared = 0;

    initial forever #20 clk_sys = ~clk_sys;

    gac_far_model i_far (.clk_sys, .clkRun, .gateReq, .extClkPin, .gateSources);

    gac_top i_dut (.clk_sys, .reset, .extClkPin, .clkSourceExt, .extClkUnlatched, .sleepMode,
        .inputPrescale, .runEnable, .wideAccessEnable, .wrLowStrobe, .wrHighStrobe, .rdLowStrobe,
        .rdHighStrobe, .wrData, .rdData, .countValue, .gateEnable, .gatePolarity, .gateSourceSelect,
        .gateSources, .compSyncEnable, .toggleGateMode, .oneShotGateMode, .armSetStrobe,
        .singlePulseArm, .gateLevel, .rolloverFlag, .rolloverClear, .rolloverEnable, .wakeRequest,
        .gateEventFlag, .gateFlagClear, .gateEventEnable, .gateEventIrq);

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp)
        begin
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
            n_mismatch++;
        end
    endtask

    // byte write, strobe held across exactly one rising edge
    task automatic wr(input logic hi, input logic [7:0] d);
        wrData = d;
        wrHighStrobe = hi;
        wrLowStrobe = ~hi;
        cyc(1);
        wrHighStrobe = 0;
        wrLowStrobe = 0;
        cyc(1); // idle edge so back-to-back calls never re-drive a strobe in one step
    endtask

    // byte read, data registered at the strobe edge
    task automatic rd(input logic hi, input logic [7:0] exp);
        rdHighStrobe = hi;
        rdLowStrobe = ~hi;
        cyc(1);
        rdHighStrobe = 0;
        rdLowStrobe = 0;
        chk("rdData", {8'h00, exp}, {8'h00, rdData});
        cyc(1);
    endtask

    task automatic pulse_arm();
        armSetStrobe = 1;
        cyc(1);
        armSetStrobe = 0;
        cyc(2);
    endtask

    task automatic stop_test();
        if (n_mismatch == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // main sequence
    initial
    begin
        cyc(16);
        reset = 0;
        cyc(2);
        chk("countValue", 16'h0000, countValue);
        wideAccessEnable = 1;
        wr(1, 8'h12);
        chk("countValue", 16'h0000, countValue);
        wr(0, 8'h34);
        chk("countValue", 16'h1234, countValue);
        rd(0, 8'h34);
        wideAccessEnable = 0;
        wr(1, 8'hab);
        chk("countValue", 16'hab34, countValue);
        wideAccessEnable = 1;
        rd(1, 8'h12);
        // preload near the top while stopped, then run from the async pin in sleep
        wr(1, 8'hff);
        wr(0, 8'hf0);
        clkSourceExt = 1;
        extClkUnlatched = 1;
        sleepMode = 1;
        rolloverEnable = 1;
        clkRun = 1;
        runEnable = 1;
        for (int i = 0; i < 400 && rolloverFlag !== 1'b1; i++)
            cyc(1);
        if (rolloverFlag !== 1'b1)
        begin
            n_mismatch++;
            stop_test();
        end
        chk("wakeRequest", 16'h0001, {15'h0, wakeRequest});
        chk("countTop", 16'h0000, {4'h0, countValue[15:4]});
        rolloverClear = 1;
        clkRun = 0;
        sleepMode = 0;
        cyc(1);
        rolloverClear = 0;
        // gated internal counting: hold while inactive, count while active
        clkSourceExt = 0;
        extClkUnlatched = 0;
        gateEnable = 1;
        gatePolarity = 1;
        cyc(8);
        held = countValue;
        cyc(40);
        chk("countValue", held, countValue);
        gatePolarity = 0;
        cyc(40);
        chk("countValue", held + 16'h000a, countValue);
        // divide by four: one count per sixteen cycles, whatever the start phase
        gateEnable = 0;
        inputPrescale = 2'h2;
        held = countValue;
        cyc(64);
        chk("countValue", held + 16'h0004, countValue);
        inputPrescale = 2'h0;
        // gate event flag with gate enable off
        gateEnable = 0;
        gatePolarity = 1;
        gateEventEnable = 1;
        gateReq = 23'h000001;
        cyc(6);
        chk("gateLevel", 16'h0001, {15'h0, gateLevel});
        // earlier polarity flips left the flag set; clear it so the fall is seen
        gateFlagClear = 1;
        cyc(1);
        gateFlagClear = 0;
        chk("gateEventFlag", 16'h0000, {15'h0, gateEventFlag});
        gateReq = 23'h000000;
        cyc(6);
        chk("gateEventIrq", 16'h0001, {15'h0, gateEventIrq});
        cyc(20);
        chk("gateEventFlag", 16'h0001, {15'h0, gateEventFlag});
        gateFlagClear = 1;
        cyc(1);
        gateFlagClear = 0;
        cyc(1);
        chk("gateEventFlag", 16'h0000, {15'h0, gateEventFlag});
        // reserved codes read as inactive, last code selectable
        gateReq = 23'h7fffff;
        gateSourceSelect = 5'h17;
        cyc(6);
        chk("gateLevel", 16'h0000, {15'h0, gateLevel});
        gateSourceSelect = 5'h02;
        cyc(6);
        chk("gateLevel", 16'h0000, {15'h0, gateLevel});
        gateSourceSelect = 5'h16;
        cyc(6);
        chk("gateLevel", 16'h0001, {15'h0, gateLevel});
        gateSourceSelect = 5'h00;
        gateReq = 23'h000000;
        // comparator copy: frozen without ticks, pass-through follows at once
        cyc(8);
        clkSourceExt = 1;
        compSyncEnable = 1;
        gateSourceSelect = 5'h13;
        gateReq = 23'h080000;
        cyc(6);
        chk("gateLevel", 16'h0000, {15'h0, gateLevel});
        compSyncEnable = 0;
        cyc(2);
        chk("gateLevel", 16'h0001, {15'h0, gateLevel});
        clkSourceExt = 0;
        gateSourceSelect = 5'h00;
        gateReq = 23'h000000;
        // single pulse: mode first, then arm
        gateEnable = 1;
        oneShotGateMode = 1;
        cyc(4);
        pulse_arm();
        chk("singlePulseArm", 16'h0001, {15'h0, singlePulseArm});
        held = countValue;
        gateReq = 23'h000001;
        cyc(40);
        gateReq = 23'h000000;
        cyc(8);
        chk("singlePulseArm", 16'h0000, {15'h0, singlePulseArm});
        chk("countMoved", 16'h0001, {15'h0, countValue !== held});
        held = countValue;
        gateReq = 23'h000001;
        cyc(40);
        gateReq = 23'h000000;
        cyc(8);
        chk("countValue", held, countValue);
        pulse_arm();
        oneShotGateMode = 0;
        cyc(2);
        chk("singlePulseArm", 16'h0000, {15'h0, singlePulseArm});
        // toggle mode: polarity already settled, toggle enabled on its own
        toggleGateMode = 1;
        gateReq = 23'h000001;
        cyc(6);
        gateReq = 23'h000000;
        cyc(6);
        chk("gateLevel", 16'h0001, {15'h0, gateLevel});
        gateReq = 23'h000001;
        cyc(6);
        chk("gateLevel", 16'h0000, {15'h0, gateLevel});
        // toggle plus one-shot: one armed capture spans a full gate cycle
        gateReq = 23'h000000;
        oneShotGateMode = 1;
        cyc(4);
        pulse_arm();
        held = countValue;
        gateReq = 23'h000001;
        cyc(8);
        gateReq = 23'h000000;
        cyc(8);
        chk("singlePulseArm", 16'h0001, {15'h0, singlePulseArm});
        gateReq = 23'h000001;
        cyc(8);
        chk("singlePulseArm", 16'h0000, {15'h0, singlePulseArm});
        chk("countMoved", 16'h0001, {15'h0, countValue !== held});
        stop_test();
    end
endmodule // gac_top_tb_top
